/* design/vfi_pkg.sv */
// Package for the vertical interrupt and field bit block
package vfi_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] VERTICAL_INTERRUPT_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] FIELD_BIT_LINES_OFFSET            = 4'h4;
    localparam logic [3:0] LINE_ID_OFFSET                    = 4'h8;

    // Field positions
    localparam int LINE_WIDTH      = 12;
    localparam int LOW_LINE_LSB    = 0;
    localparam int HIGH_LINE_LSB   = 16;
    localparam int FIELD_ONE_EN_BIT = 15;
    localparam int FIELD_TWO_EN_BIT = 31;

    // Reset values
    localparam logic [31:0] VERTICAL_INTERRUPT_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] FIELD_BIT_LINES_RESET            = 32'h0000_0000;

    // Writable bit masks; reserved bits stay zero
    localparam logic [31:0] VERTICAL_INTERRUPT_CONTROL_MASK = 32'h8FFF_8FFF;
    localparam logic [31:0] FIELD_BIT_LINES_MASK            = 32'h0FFF_0FFF;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Line timing inputs from the display port
    typedef struct packed {
        logic [LINE_WIDTH-1:0] frame_line_counter;
        logic                  line_start;
        logic                  line_end;
        logic                  field_two;
        logic                  raw_mode;
    } vfi_timing_type;

endpackage

/* design/vfi_top.sv */
// Vertical interrupt and field bit generation with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) Interrupt when programmed line of field completes
// (R2) Bit 15 enables field one interrupt
// (R3) Bit 31 enables field two interrupt
// (R4) Bits 11:0 hold field one line
// (R5) Bits 27:16 hold field two line
// (R6) Reserved bits read zero, writes ignored
// (R7) F cleared at EAV of clear line
// (R8) F stays until set line, then one
// (R9) F independent of external field output
// (R10) Software keeps F change after V fall
// (R11) Progressive: set line beyond frame height
// (R12) Bits 27:16 give field bit set line
// (R13) Bits 11:0 give field bit clear line
// (R14) Interrupt is one pulse per matching line
// (R15) Raw mode: clear and set lines ignored
module vfi_top (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [3:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [3:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire vfi_pkg::vfi_timing_type timing,
    output logic                        vertical_interrupt,
    output logic                        field_bit
);

    logic [31:0] vertical_interrupt_control;
    logic [31:0] field_bit_lines;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        write_fire;
    logic        write_hit;
    logic        read_hit;
    logic [31:0] next_rdata;

    // Apply byte strobes and writable mask to a register
    function automatic logic [31:0] merge(input logic [31:0] old_value, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                result[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return result & mask;
    endfunction

    // Known register offsets
    function automatic logic decoded(input logic [3:0] addr);
        return addr == vfi_pkg::VERTICAL_INTERRUPT_CONTROL_OFFSET || addr == vfi_pkg::FIELD_BIT_LINES_OFFSET
            || addr == vfi_pkg::LINE_ID_OFFSET;
    endfunction

    // Ready while the matching half is not yet held and no write response is pending
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign write_fire    = aw_held && w_held && !s_axi_bvalid;
    assign write_hit     = aw_addr == vfi_pkg::VERTICAL_INTERRUPT_CONTROL_OFFSET
                        || aw_addr == vfi_pkg::FIELD_BIT_LINES_OFFSET;

    // Capture write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (write_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Capture write data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (write_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= vfi_pkg::RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= write_hit ? vfi_pkg::RESP_OKAY : vfi_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Vertical interrupt control register, reserved bits masked off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vertical_interrupt_control <= vfi_pkg::VERTICAL_INTERRUPT_CONTROL_RESET;
        end else if (write_fire && aw_addr == vfi_pkg::VERTICAL_INTERRUPT_CONTROL_OFFSET) begin
            vertical_interrupt_control <= merge(vertical_interrupt_control, w_data, w_strb,
                                                vfi_pkg::VERTICAL_INTERRUPT_CONTROL_MASK); // [R6]
        end
    end

    // Field bit lines register, reserved bits masked off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            field_bit_lines <= vfi_pkg::FIELD_BIT_LINES_RESET;
        end else if (write_fire && aw_addr == vfi_pkg::FIELD_BIT_LINES_OFFSET) begin
            field_bit_lines <= merge(field_bit_lines, w_data, w_strb, vfi_pkg::FIELD_BIT_LINES_MASK); // [R6]
        end
    end

    // Read mux; third word shows live line and field state
    assign read_hit = decoded(s_axi_araddr);
    always_comb begin
        unique case (s_axi_araddr)
            vfi_pkg::VERTICAL_INTERRUPT_CONTROL_OFFSET: next_rdata = vertical_interrupt_control;
            vfi_pkg::FIELD_BIT_LINES_OFFSET:            next_rdata = field_bit_lines;
            vfi_pkg::LINE_ID_OFFSET:
                next_rdata = {15'h0000, field_bit, 4'h0, timing.frame_line_counter};
            default:                                    next_rdata = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= vfi_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= read_hit ? vfi_pkg::RESP_OKAY : vfi_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Interrupt line and enable of the current field
    logic [vfi_pkg::LINE_WIDTH-1:0] irq_line;
    logic                           irq_enable;
    logic                           irq_match;
    assign irq_line   = timing.field_two
                      ? vertical_interrupt_control[vfi_pkg::HIGH_LINE_LSB +: vfi_pkg::LINE_WIDTH]  // [R5]
                      : vertical_interrupt_control[vfi_pkg::LOW_LINE_LSB +: vfi_pkg::LINE_WIDTH];  // [R4]
    assign irq_enable = timing.field_two
                      ? vertical_interrupt_control[vfi_pkg::FIELD_TWO_EN_BIT]  // [R3]
                      : vertical_interrupt_control[vfi_pkg::FIELD_ONE_EN_BIT]; // [R2]
    assign irq_match  = timing.line_end && timing.frame_line_counter == irq_line;

    // One pulse at end of the matching line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vertical_interrupt <= 1'b0;
        end else begin
            vertical_interrupt <= irq_match && irq_enable; // [R1] [R14]
        end
    end

    // F bit steered only by line counter, line start, raw mode and programmed lines
    logic [vfi_pkg::LINE_WIDTH-1:0] set_line;
    logic [vfi_pkg::LINE_WIDTH-1:0] clear_line;
    assign set_line   = field_bit_lines[vfi_pkg::HIGH_LINE_LSB +: vfi_pkg::LINE_WIDTH]; // [R12]
    assign clear_line = field_bit_lines[vfi_pkg::LOW_LINE_LSB +: vfi_pkg::LINE_WIDTH];  // [R13]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            field_bit <= 1'b0;
        end else if (timing.line_start && !timing.raw_mode) begin // [R15] [R9]
            if (timing.frame_line_counter == clear_line) begin
                field_bit <= 1'b0; // [R7]
            end else if (timing.frame_line_counter == set_line) begin
                field_bit <= 1'b1; // [R8]
            end
        end
    end

endmodule
`default_nettype wire

/* dv/vfi_line_src.sv */
// Line timing source model for the block
`timescale 1ns/1ps
`default_nettype none
module vfi_line_src #(parameter int LEN = 6, parameter int H = 10) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   raw_mode,
    output var vfi_pkg::vfi_timing_type timing
);
    logic [3:0]  ph;
    logic [11:0] ln;
    // Pixel phase and frame line count, lines 1 to H
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph <= 4'h0;
            ln <= 12'h1;
        end else begin
            ph <= (ph == LEN - 1) ? 4'h0 : ph + 4'h1;
            if (ph == LEN - 1) ln <= (ln == H) ? 12'h1 : ln + 12'h1;
        end
    end
    // Upper half of the frame is field two
    assign timing = '{ln, ph == 4'h0, ph == LEN - 1, ln > H / 2, raw_mode};
endmodule
`default_nettype wire

/* dv/vfi_top_asserts.sv */
// Port assertions for the vertical interrupt and field bit block
`timescale 1ns/1ps
`default_nettype none
module vfi_top_asserts (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic                    s_axi_arvalid,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input wire vfi_pkg::vfi_timing_type timing,
    input wire logic                    vertical_interrupt,
    input wire logic                    field_bit
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_IRQ_PULSE: assert property (vertical_interrupt |=> !vertical_interrupt [*4])
        else $error("interrupt pulse too long");
    AST_IRQ_CAUSE: assert property (vertical_interrupt |-> $past(timing.line_end))
        else $error("interrupt without line end");
    AST_F_HOLD: assert property (!(timing.line_start && !timing.raw_mode) |=> $stable(field_bit))
        else $error("field bit moved off line start");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_R_ANS: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered");
    AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp != vfi_pkg::RESP_OKAY |-> s_axi_rdata == 32'h0)
        else $error("error read not zero");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    AST_F_RAW: assert property (timing.raw_mode |=> $stable(field_bit))
        else $error("field bit moved in raw mode");
endmodule
bind vfi_top vfi_top_asserts chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timing, .vertical_interrupt, .field_bit);
`default_nettype wire

/* dv/vfi_top_bench.sv */
// Testbench for the vertical interrupt and field bit block
`timescale 1ns/1ps
`default_nettype none
module vfi_top_bench;
    logic aclk = 0, aresetn = 0, raw = 0, fl [0:15], lastf = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, vertical_interrupt, field_bit;
    logic [11:0] prev = 12'h0;
    vfi_pkg::vfi_timing_type timing;
    int errors = 0, check_count = 0, cyc = 0, irqs = 0, isum = 0, fchg = 0;
    always #5 aclk = ~aclk;
    vfi_line_src src_u (.aclk, .aresetn, .raw_mode(raw), .timing);
    vfi_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timing, .vertical_interrupt,
        .field_bit);
    // Interrupt tally, field bit per line and cycle limit
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            stop_test();
        end
        if (vertical_interrupt) isum += prev;
        if (vertical_interrupt) irqs++;
        if (timing.line_end) fl[timing.frame_line_counter[3:0]] = field_bit;
        if (field_bit !== lastf) fchg++;
        lastf = field_bit;
        prev = timing.frame_line_counter;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] e);
        logic ta, tw, tb;
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, e});
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
        @(posedge aclk);
    endtask
    task rd(input logic [3:0] ad, input logic [31:0] e, input logic [31:0] m);
        logic ta, tr;
        logic [1:0] er;
        er = (ad == 4'hC) ? vfi_pkg::RESP_SLVERR : vfi_pkg::RESP_OKAY;
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            if (tr) chk("rdata", s_axi_rdata & m, e);
            if (tr) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end
        @(posedge aclk);
    endtask
    task frm();
        @(posedge aclk iff (timing.line_start && timing.frame_line_counter == 12'h1));
    endtask
    // One frame with given interrupt settings: pulse count and line sum
    task irqt(input logic [31:0] d, input int n, input int s);
        int a, b;
        wr(4'h0, d, vfi_pkg::RESP_OKAY);
        frm();
        a = irqs;
        b = isum;
        frm();
        chk("irqs", irqs - a, n);
        chk("isum", isum - b, s);
    endtask
    task stop_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        int base;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 32'h0, 32'hFFFF_FFFF);
        rd(4'h4, 32'h0, 32'hFFFF_FFFF);
        wr(4'h0, 32'hFFFF_FFFF, vfi_pkg::RESP_OKAY);
        rd(4'h0, 32'h8FFF_8FFF, 32'hFFFF_FFFF);
        wr(4'h4, 32'hFFFF_FFFF, vfi_pkg::RESP_OKAY);
        rd(4'h4, 32'h0FFF_0FFF, 32'hFFFF_FFFF);
        wr(4'hC, 32'h1, vfi_pkg::RESP_SLVERR);
        wr(4'h8, 32'h1, vfi_pkg::RESP_SLVERR);
        rd(4'hC, 32'h0, 32'hFFFF_FFFF);
        wr(4'h4, 32'h0007_0002, vfi_pkg::RESP_OKAY);
        irqt(32'h8008_8003, 2, 11);
        for (int l = 1; l < 11; l++) chk("fbit", {31'h0, fl[l]}, {31'h0, l >= 7 || l < 2});
        irqt(32'h8008_0003, 1, 8);
        irqt(32'h0008_8003, 1, 3);
        irqt(32'h8003_8008, 0, 0);
        wr(4'h4, 32'h0FFF_0002, vfi_pkg::RESP_OKAY);
        irqt(32'h0, 0, 0);
        base = fchg;
        frm();
        chk("fchg", fchg - base, 0);
        rd(4'h8, 32'h0, 32'hFFFF_F000);
        raw <= 1'b1;
        irqt(32'h0, 0, 0);
        wr(4'h4, 32'h0007_0002, vfi_pkg::RESP_OKAY);
        base = fchg;
        frm();
        frm();
        chk("rawf", fchg - base, 0);
        chk("f", {31'h0, field_bit}, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
